/* pin_select_pkg.sv */
// constants for the shared pin function select block
package pin_select_pkg;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int        ADDR_W      = 8;
	localparam int        DATA_W      = 32;
	localparam logic [7:0] OFS_GP_EN   = 8'h00;
	localparam logic [7:0] OFS_GP_DIR  = 8'h04;
	localparam logic [7:0] OFS_GP_DATA = 8'h08;
	localparam logic [7:0] OFS_GP_PINS = 8'h0C;
	localparam logic [7:0] OFS_STRAPS  = 8'h10;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		REG_GP_EN,
		REG_GP_DIR,
		REG_GP_DATA,
		REG_GP_PINS,
		REG_STRAPS,
		REG_NONE
	} reg_sel_t;

	// ----------------------------------------------------------------
	// general-purpose pins
	// ----------------------------------------------------------------
	localparam int           GP_W        = 16;
	localparam logic [15:0] GP_IMPL_MASK = 16'hFF06;
	localparam logic [15:0] GP_EN_RST    = 16'h0000;
	localparam logic [15:0] GP_DIR_RST   = 16'h0000;
	localparam logic [15:0] GP_DATA_RST  = 16'h0000;
	localparam int           PIN_QCLK    = 1;
	localparam int           PIN_CLK6    = 2;
	localparam int           PIN_SER2CLK = 8;
	localparam int           PIN_PCI_LO  = 9;
	localparam int           PCI_GP_W    = 7;

	// ----------------------------------------------------------------
	// strap-selected pin groups
	// ----------------------------------------------------------------
	localparam int SH1_W       = 7;
	localparam int SER1_SOLO_W = 3;
	localparam int CELL_SOLO_W = 8;
	localparam int PCI_SOLO_W  = 4;
	localparam int SER2_W      = 3;
	localparam int HOST_W      = 42;
	localparam logic [41:0] HOST_NARROW_MASK = 42'h3FF_0000_FFFF;
	localparam logic [41:0] HOST_WIDE_IN_MASK = 42'h3BF_FFFF_FFFF;
	localparam int STRAP_W        = 3;
	localparam int STRAP_CELL_BIT = 0;
	localparam int STRAP_PCI_BIT  = 1;
	localparam int STRAP_WIDE_BIT = 2;
	localparam logic [1:0] CAP_WAIT = 2'h2;

	// ----------------------------------------------------------------
	// synchroniser vector layout
	// ----------------------------------------------------------------
	localparam int SY_GP    = 0;
	localparam int SY_SH1   = 16;
	localparam int SY_SER2  = 23;
	localparam int SY_HOST  = 26;
	localparam int SY_STRAP = 68;
	localparam int SY_W     = 71;

endpackage : pin_select_pkg

/* shared_pin_function_select.sv */
// shared pin function select with register slave
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - after reset pins 1, 2 and 8 carry their clock defaults, gpio off.
// - setting the gpio select bit of pin 1, 2 or 8 hands it to gpio at any time, of pins 9-15 only with pci strap 0.
// - an enabled gpio pin is an input at direction 0, an output at 1.
// - pins 9 to 15 act as gpio only while the pci strap is 0.
// - cell strap 0 routes the shared pins to serial port one.
// - cell strap 1 routes them to the cell tx and rx address lines.
// - pci strap 0 routes the shared pins to the host port.
// - pci strap 1 gives host pins and pins 9-15 to pci, eeprom on sp2.
// - a strapped-off cell or pci block keeps its own pins high-z.
// - with cells selected the solo serial-one pins stay high-z.
// - the width strap picks a 32 or 16 bit host port, top half high-z.
// - strapped groups stay fixed till reset, software pins may change.
module shared_pin_function_select (
	// clock and reset
	input  wire logic                 CLK_IN,
	input  wire logic                 RESETN_IN,
	// axi4-lite write
	input  wire logic [7:0]           AWADDR_IN,
	input  wire logic                 AWVALID_IN,
	output logic                      AWREADY_OUT,
	input  wire logic [31:0]          WDATA_IN,
	input  wire logic [3:0]           WSTRB_IN,
	input  wire logic                 WVALID_IN,
	output logic                      WREADY_OUT,
	output logic [1:0]                BRESP_OUT,
	output logic                      BVALID_OUT,
	input  wire logic                 BREADY_IN,
	// axi4-lite read
	input  wire logic [7:0]           ARADDR_IN,
	input  wire logic                 ARVALID_IN,
	output logic                      ARREADY_OUT,
	output logic [31:0]               RDATA_OUT,
	output logic [1:0]                RRESP_OUT,
	output logic                      RVALID_OUT,
	input  wire logic                 RREADY_IN,
	// strap pins and latched selections
	input  wire logic                 CELL_BUS_STRAP_PIN_IN,
	input  wire logic                 PCI_SEL_STRAP_PIN_IN,
	input  wire logic                 HOST_WIDTH_STRAP_IN,
	output logic                      CELL_BUS_SELECT_STRAP_OUT,
	output logic                      PCI_SELECT_STRAP_OUT,
	output logic                      HOST_PORT_WIDE_OUT,
	// general-purpose pins
	input  wire logic [15:0]          GP_PIN_IN,
	output logic [15:0]               GP_PIN_OUT,
	output logic [15:0]               GP_PIN_OE_OUT,
	// default functions of the gpio pins
	input  wire logic                 QUARTER_RATE_CLOCK_OUT_IN,
	input  wire logic                 SIXTH_RATE_CLOCK_OUT_IN,
	output logic                      SERIAL2_EXT_CLOCK_IN_OUT,
	input  wire logic [6:0]           PCI_GP_DRV_IN,
	input  wire logic [6:0]           PCI_GP_EN_IN,
	output logic [6:0]                PCI_GP_RCV_OUT,
	// serial-one / cell address shared pins
	input  wire logic [6:0]           SH1_PIN_IN,
	output logic [6:0]                SH1_PIN_OUT,
	output logic [6:0]                SH1_PIN_OE_OUT,
	input  wire logic [6:0]           SERIAL_ONE_DRV_IN,
	input  wire logic [6:0]           SERIAL_ONE_EN_IN,
	output logic [6:0]                SERIAL_ONE_RCV_OUT,
	input  wire logic [6:0]           CELL_ADDR_DRV_IN,
	input  wire logic [6:0]           CELL_ADDR_EN_IN,
	output logic [6:0]                CELL_ADDR_RCV_OUT,
	// stand-alone pins of strapped peripherals
	input  wire logic [2:0]           SER1_SOLO_DRV_IN,
	input  wire logic [2:0]           SER1_SOLO_EN_IN,
	output logic [2:0]                SER1_SOLO_PIN_OUT,
	output logic [2:0]                SER1_SOLO_PIN_OE_OUT,
	input  wire logic [7:0]           CELL_SOLO_DRV_IN,
	input  wire logic [7:0]           CELL_SOLO_EN_IN,
	output logic [7:0]                CELL_SOLO_PIN_OUT,
	output logic [7:0]                CELL_SOLO_PIN_OE_OUT,
	input  wire logic [3:0]           PCI_SOLO_DRV_IN,
	input  wire logic [3:0]           PCI_SOLO_EN_IN,
	output logic [3:0]                PCI_SOLO_PIN_OUT,
	output logic [3:0]                PCI_SOLO_PIN_OE_OUT,
	// serial-two / eeprom shared pins
	input  wire logic [2:0]           SER2_PIN_IN,
	output logic [2:0]                SER2_PIN_OUT,
	output logic [2:0]                SER2_PIN_OE_OUT,
	input  wire logic [2:0]           SERIAL_TWO_DRV_IN,
	input  wire logic [2:0]           SERIAL_TWO_EN_IN,
	output logic [2:0]                SERIAL_TWO_RCV_OUT,
	input  wire logic [2:0]           EEPROM_DRV_IN,
	input  wire logic [2:0]           EEPROM_EN_IN,
	output logic [2:0]                EEPROM_RCV_OUT,
	// host port / pci shared pins
	input  wire logic [41:0]          HOST_PIN_IN,
	output logic [41:0]               HOST_PIN_OUT,
	output logic [41:0]               HOST_PIN_OE_OUT,
	input  wire logic [41:0]          HOST_PORT_DRV_IN,
	input  wire logic [41:0]          HOST_PORT_EN_IN,
	output logic [41:0]               HOST_PORT_RCV_OUT,
	input  wire logic [41:0]          PCI_BUS_DRV_IN,
	input  wire logic [41:0]          PCI_BUS_EN_IN,
	output logic [41:0]               PCI_BUS_RCV_OUT
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [pin_select_pkg::SY_W-1:0]    sync1;
	logic [pin_select_pkg::SY_W-1:0]    sync2;
	logic [1:0]                         cap_cnt;
	logic                               captured;
	logic                               cell_sel;
	logic                               pci_sel;
	logic                               host_wide;
	logic [15:0]                        gp_en;
	logic [15:0]                        gp_dir;
	logic [15:0]                        gp_data;
	logic [15:0]                        dflt_out;
	logic [15:0]                        dflt_oe;
	logic [15:0]                        next_gp_out;
	logic [15:0]                        next_gp_oe;
	logic [15:0]                        gp_active;
	logic [15:0]                        gp_sync;
	logic [6:0]                         sh1_sync;
	logic [2:0]                         ser2_sync;
	logic [41:0]                        host_sync;
	logic [41:0]                        host_mask;
	logic                               aw_got;
	logic                               w_got;
	logic [7:0]                         aw_addr;
	logic [31:0]                        w_data;
	logic [3:0]                         w_strb;
	logic                               do_write;
	pin_select_pkg::reg_sel_t           wr_sel;
	logic [15:0]                        byte_mask;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic pin_select_pkg::reg_sel_t reg_of(
		input logic [7:0] addr);
		unique case (addr)
			pin_select_pkg::OFS_GP_EN:   reg_of = pin_select_pkg::REG_GP_EN;
			pin_select_pkg::OFS_GP_DIR:  reg_of = pin_select_pkg::REG_GP_DIR;
			pin_select_pkg::OFS_GP_DATA: reg_of = pin_select_pkg::REG_GP_DATA;
			pin_select_pkg::OFS_GP_PINS: reg_of = pin_select_pkg::REG_GP_PINS;
			pin_select_pkg::OFS_STRAPS:  reg_of = pin_select_pkg::REG_STRAPS;
			default:                     reg_of = pin_select_pkg::REG_NONE;
		endcase
	endfunction : reg_of

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {HOST_WIDTH_STRAP_IN, PCI_SEL_STRAP_PIN_IN,
				CELL_BUS_STRAP_PIN_IN, HOST_PIN_IN, SER2_PIN_IN,
				SH1_PIN_IN, GP_PIN_IN};
			sync2 <= sync1;
		end
	end

	assign gp_sync   = sync2[pin_select_pkg::SY_GP +: 16];
	assign sh1_sync  = sync2[pin_select_pkg::SY_SH1 +: 7];
	assign ser2_sync = sync2[pin_select_pkg::SY_SER2 +: 3];
	assign host_sync = sync2[pin_select_pkg::SY_HOST +: 42];

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cap_cnt   <= 2'h0;
			captured  <= 1'b0;
			cell_sel  <= 1'b0;
			pci_sel   <= 1'b0;
			host_wide <= 1'b0;
		end else if (!captured) begin
			if (cap_cnt == pin_select_pkg::CAP_WAIT) begin
				captured  <= 1'b1;
				cell_sel  <= sync2[pin_select_pkg::SY_STRAP
					+ pin_select_pkg::STRAP_CELL_BIT];
				pci_sel   <= sync2[pin_select_pkg::SY_STRAP
					+ pin_select_pkg::STRAP_PCI_BIT];
				host_wide <= sync2[pin_select_pkg::SY_STRAP
					+ pin_select_pkg::STRAP_WIDE_BIT];
			end else begin
				cap_cnt <= cap_cnt + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// register write path
	// ----------------------------------------------------------------
	assign do_write  = aw_got && w_got && !BVALID_OUT;
	assign wr_sel    = reg_of(aw_addr);
	assign byte_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}}
		& pin_select_pkg::GP_IMPL_MASK;

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			AWREADY_OUT <= 1'b1;
			WREADY_OUT  <= 1'b1;
			BVALID_OUT  <= 1'b0;
			BRESP_OUT   <= pin_select_pkg::RESP_OKAY;
			aw_got      <= 1'b0;
			w_got       <= 1'b0;
			aw_addr     <= 8'h00;
			w_data      <= 32'h0000_0000;
			w_strb      <= 4'h0;
		end else begin
			if (AWVALID_IN && AWREADY_OUT) begin
				aw_got      <= 1'b1;
				aw_addr     <= AWADDR_IN;
				AWREADY_OUT <= 1'b0;
			end
			if (WVALID_IN && WREADY_OUT) begin
				w_got      <= 1'b1;
				w_data     <= WDATA_IN;
				w_strb     <= WSTRB_IN;
				WREADY_OUT <= 1'b0;
			end
			if (do_write) begin
				aw_got     <= 1'b0;
				w_got      <= 1'b0;
				BVALID_OUT <= 1'b1;
				BRESP_OUT  <= (wr_sel == pin_select_pkg::REG_GP_EN
					|| wr_sel == pin_select_pkg::REG_GP_DIR
					|| wr_sel == pin_select_pkg::REG_GP_DATA)
					? pin_select_pkg::RESP_OKAY
					: pin_select_pkg::RESP_SLVERR;
			end
			if (BVALID_OUT && BREADY_IN) begin
				BVALID_OUT  <= 1'b0;
				AWREADY_OUT <= 1'b1;
				WREADY_OUT  <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			gp_en   <= pin_select_pkg::GP_EN_RST;
			gp_dir  <= pin_select_pkg::GP_DIR_RST;
			gp_data <= pin_select_pkg::GP_DATA_RST;
		end else if (do_write) begin
			if (wr_sel == pin_select_pkg::REG_GP_EN)
				gp_en <= (gp_en & ~byte_mask)
					| (w_data[15:0] & byte_mask);
			if (wr_sel == pin_select_pkg::REG_GP_DIR)
				gp_dir <= (gp_dir & ~byte_mask)
					| (w_data[15:0] & byte_mask);
			if (wr_sel == pin_select_pkg::REG_GP_DATA)
				gp_data <= (gp_data & ~byte_mask)
					| (w_data[15:0] & byte_mask);
		end
	end

	// ----------------------------------------------------------------
	// register read path
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ARREADY_OUT <= 1'b1;
			RVALID_OUT  <= 1'b0;
			RDATA_OUT   <= 32'h0000_0000;
			RRESP_OUT   <= pin_select_pkg::RESP_OKAY;
		end else if (ARVALID_IN && ARREADY_OUT) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT  <= 1'b1;
			RRESP_OUT   <= pin_select_pkg::RESP_OKAY;
			unique case (reg_of(ARADDR_IN))
				pin_select_pkg::REG_GP_EN:
					RDATA_OUT <= {16'h0000, gp_en};
				pin_select_pkg::REG_GP_DIR:
					RDATA_OUT <= {16'h0000, gp_dir};
				pin_select_pkg::REG_GP_DATA:
					RDATA_OUT <= {16'h0000, gp_data};
				pin_select_pkg::REG_GP_PINS:
					RDATA_OUT <= {16'h0000,
						gp_sync & pin_select_pkg::GP_IMPL_MASK};
				pin_select_pkg::REG_STRAPS:
					RDATA_OUT <= {29'h0000_0000,
						host_wide, pci_sel, cell_sel};
				default: begin
					RDATA_OUT <= 32'h0000_0000;
					RRESP_OUT <= pin_select_pkg::RESP_SLVERR;
				end
			endcase
		end else if (RVALID_OUT && RREADY_IN) begin
			RVALID_OUT  <= 1'b0;
			ARREADY_OUT <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// gpio pin mux
	// ----------------------------------------------------------------
	always_comb begin
		dflt_out = 16'h0000;
		dflt_oe  = 16'h0000;
		dflt_out[pin_select_pkg::PIN_QCLK] = QUARTER_RATE_CLOCK_OUT_IN;
		dflt_oe[pin_select_pkg::PIN_QCLK]  = 1'b1;
		dflt_out[pin_select_pkg::PIN_CLK6] = SIXTH_RATE_CLOCK_OUT_IN;
		dflt_oe[pin_select_pkg::PIN_CLK6]  = 1'b1;
		dflt_out[15:9] = PCI_GP_DRV_IN;
		dflt_oe[15:9]  = pci_sel ? PCI_GP_EN_IN : 7'h00;
	end

	genvar gi;
	generate
		for (gi = 0; gi < pin_select_pkg::GP_W; gi++) begin : g_gp
			if (gi >= pin_select_pkg::PIN_PCI_LO) begin : g_pci
				assign gp_active[gi] = gp_en[gi] && !pci_sel;
			end else begin : g_plain
				assign gp_active[gi] = gp_en[gi];
			end
			assign next_gp_out[gi] = gp_active[gi]
				? gp_data[gi] : dflt_out[gi];
			assign next_gp_oe[gi] = gp_active[gi]
				? gp_dir[gi] : dflt_oe[gi];
		end
	endgenerate

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			GP_PIN_OUT               <= 16'h0000;
			GP_PIN_OE_OUT            <= 16'h0000;
			SERIAL2_EXT_CLOCK_IN_OUT <= 1'b0;
			PCI_GP_RCV_OUT           <= 7'h00;
		end else begin
			GP_PIN_OUT    <= next_gp_out;
			GP_PIN_OE_OUT <= next_gp_oe;
			SERIAL2_EXT_CLOCK_IN_OUT <=
				!gp_active[pin_select_pkg::PIN_SER2CLK]
				&& gp_sync[pin_select_pkg::PIN_SER2CLK];
			PCI_GP_RCV_OUT <= pci_sel ? gp_sync[15:9] : 7'h00;
		end
	end

	// ----------------------------------------------------------------
	// strap-selected groups
	// ----------------------------------------------------------------
	assign host_mask = host_wide ? '1 : pin_select_pkg::HOST_NARROW_MASK;

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			CELL_BUS_SELECT_STRAP_OUT <= 1'b0;
			PCI_SELECT_STRAP_OUT      <= 1'b0;
			HOST_PORT_WIDE_OUT        <= 1'b0;
			SH1_PIN_OUT               <= 7'h00;
			SH1_PIN_OE_OUT            <= 7'h00;
			SERIAL_ONE_RCV_OUT        <= 7'h00;
			CELL_ADDR_RCV_OUT         <= 7'h00;
			SER1_SOLO_PIN_OUT         <= 3'h0;
			SER1_SOLO_PIN_OE_OUT      <= 3'h0;
			CELL_SOLO_PIN_OUT         <= 8'h00;
			CELL_SOLO_PIN_OE_OUT      <= 8'h00;
			PCI_SOLO_PIN_OUT          <= 4'h0;
			PCI_SOLO_PIN_OE_OUT       <= 4'h0;
			SER2_PIN_OUT              <= 3'h0;
			SER2_PIN_OE_OUT           <= 3'h0;
			SERIAL_TWO_RCV_OUT        <= 3'h0;
			EEPROM_RCV_OUT            <= 3'h0;
			HOST_PIN_OUT              <= '0;
			HOST_PIN_OE_OUT           <= '0;
			HOST_PORT_RCV_OUT         <= '0;
			PCI_BUS_RCV_OUT           <= '0;
		end else begin
			CELL_BUS_SELECT_STRAP_OUT <= cell_sel;
			PCI_SELECT_STRAP_OUT      <= pci_sel;
			HOST_PORT_WIDE_OUT        <= host_wide;
			// serial port one against cell address lines
			SH1_PIN_OUT    <= cell_sel ? CELL_ADDR_DRV_IN
				: SERIAL_ONE_DRV_IN;
			SH1_PIN_OE_OUT <= cell_sel ? CELL_ADDR_EN_IN
				: SERIAL_ONE_EN_IN;
			SERIAL_ONE_RCV_OUT <= cell_sel ? 7'h00 : sh1_sync;
			CELL_ADDR_RCV_OUT  <= cell_sel ? sh1_sync : 7'h00;
			SER1_SOLO_PIN_OUT    <= SER1_SOLO_DRV_IN;
			SER1_SOLO_PIN_OE_OUT <= cell_sel ? 3'h0
				: SER1_SOLO_EN_IN;
			CELL_SOLO_PIN_OUT    <= CELL_SOLO_DRV_IN;
			CELL_SOLO_PIN_OE_OUT <= cell_sel ? CELL_SOLO_EN_IN
				: 8'h00;
			PCI_SOLO_PIN_OUT     <= PCI_SOLO_DRV_IN;
			PCI_SOLO_PIN_OE_OUT  <= pci_sel ? PCI_SOLO_EN_IN
				: 4'h0;
			// serial port two against eeprom lines
			SER2_PIN_OUT    <= pci_sel ? EEPROM_DRV_IN
				: SERIAL_TWO_DRV_IN;
			SER2_PIN_OE_OUT <= pci_sel ? EEPROM_EN_IN
				: SERIAL_TWO_EN_IN;
			SERIAL_TWO_RCV_OUT <= pci_sel ? 3'h0 : ser2_sync;
			EEPROM_RCV_OUT     <= pci_sel ? ser2_sync : 3'h0;
			// host port against pci bus
			HOST_PIN_OUT    <= pci_sel ? PCI_BUS_DRV_IN
				: HOST_PORT_DRV_IN;
			HOST_PIN_OE_OUT <= pci_sel ? PCI_BUS_EN_IN
				: (HOST_PORT_EN_IN & host_mask);
			HOST_PORT_RCV_OUT <= pci_sel ? '0
				: (host_sync & host_mask & (host_wide
				? pin_select_pkg::HOST_WIDE_IN_MASK : '1));
			PCI_BUS_RCV_OUT <= pci_sel ? host_sync : '0;
		end
	end

endmodule : shared_pin_function_select

/* pin_select_properties.sv */
// concurrent checks on the shared pin select ports
`timescale 1ns/10ps
module pin_select_checker (
	// clock, reset and straps
	input wire logic        CLK_IN, RESETN_IN,
	input wire logic        CELL_BUS_STRAP_PIN_IN, PCI_SEL_STRAP_PIN_IN,
	input wire logic        HOST_WIDTH_STRAP_IN, CELL_BUS_SELECT_STRAP_OUT,
	input wire logic        PCI_SELECT_STRAP_OUT, HOST_PORT_WIDE_OUT,
	input wire logic        QUARTER_RATE_CLOCK_OUT_IN,
	input wire logic        SIXTH_RATE_CLOCK_OUT_IN,
	// pins and peripheral sides
	input wire logic [15:0] GP_PIN_OE_OUT, GP_PIN_OUT,
	input wire logic [6:0]  SH1_PIN_OE_OUT, SERIAL_ONE_EN_IN, CELL_ADDR_EN_IN,
	input wire logic [6:0]  PCI_GP_EN_IN, SH1_PIN_OUT, SERIAL_ONE_DRV_IN,
	input wire logic [6:0]  CELL_ADDR_DRV_IN,
	input wire logic [2:0]  SER1_SOLO_PIN_OE_OUT, SER2_PIN_OE_OUT, EEPROM_EN_IN,
	input wire logic [7:0]  CELL_SOLO_PIN_OE_OUT,
	input wire logic [3:0]  PCI_SOLO_PIN_OE_OUT,
	input wire logic [41:0] HOST_PIN_OE_OUT, HOST_PORT_EN_IN, PCI_BUS_EN_IN,
	input wire logic [41:0] HOST_PIN_OUT, HOST_PORT_DRV_IN, PCI_BUS_DRV_IN
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	AST_STRAP_LATCH: assert property ($rose(RESETN_IN) ##4 1 |->
		{CELL_BUS_SELECT_STRAP_OUT, PCI_SELECT_STRAP_OUT, HOST_PORT_WIDE_OUT} ==
		$past({CELL_BUS_STRAP_PIN_IN, PCI_SEL_STRAP_PIN_IN,
		HOST_WIDTH_STRAP_IN}, 4)) else $error("strap latch wrong");
	AST_STRAP_FIXED: assert property ($past(RESETN_IN, 5) |->
		$stable({CELL_BUS_SELECT_STRAP_OUT, PCI_SELECT_STRAP_OUT,
		HOST_PORT_WIDE_OUT})) else $error("strap selection moved");
	AST_CELL_HIZ: assert property (!CELL_BUS_SELECT_STRAP_OUT |->
		CELL_SOLO_PIN_OE_OUT == 8'h00) else $error("cell pins driven");
	AST_PCI_HIZ: assert property (!PCI_SELECT_STRAP_OUT |->
		PCI_SOLO_PIN_OE_OUT == 4'h0) else $error("pci pins driven");
	AST_SER1_HIZ: assert property (CELL_BUS_SELECT_STRAP_OUT |->
		SER1_SOLO_PIN_OE_OUT == 3'h0) else $error("serial one pins driven");
	AST_SER1_ROUTE: assert property (!CELL_BUS_SELECT_STRAP_OUT |->
		SH1_PIN_OE_OUT == $past(SERIAL_ONE_EN_IN) &&
		SH1_PIN_OUT == $past(SERIAL_ONE_DRV_IN))
		else $error("serial one not routed");
	AST_CELL_ROUTE: assert property (CELL_BUS_SELECT_STRAP_OUT |->
		SH1_PIN_OE_OUT == $past(CELL_ADDR_EN_IN) &&
		SH1_PIN_OUT == $past(CELL_ADDR_DRV_IN))
		else $error("cell address not routed");
	AST_HOST_ROUTE: assert property (!PCI_SELECT_STRAP_OUT |->
		HOST_PIN_OE_OUT[31:0] == ($past(HOST_PORT_EN_IN[31:0]) &
		(HOST_PORT_WIDE_OUT ? 32'hFFFFFFFF : 32'h0000FFFF)) &&
		HOST_PIN_OUT == $past(HOST_PORT_DRV_IN))
		else $error("host port not routed");
	AST_PCI_ROUTE: assert property (PCI_SELECT_STRAP_OUT |->
		HOST_PIN_OE_OUT == $past(PCI_BUS_EN_IN) &&
		HOST_PIN_OUT == $past(PCI_BUS_DRV_IN) &&
		SER2_PIN_OE_OUT == $past(EEPROM_EN_IN)) else $error("pci not routed");
	AST_PCI_GP: assert property (PCI_SELECT_STRAP_OUT |->
		GP_PIN_OE_OUT[15:9] == $past(PCI_GP_EN_IN))
		else $error("gpio used while pci on");
	AST_CLK_DFLT: assert property ($rose(RESETN_IN) |-> ##1
		GP_PIN_OE_OUT[2:1] == 2'h3 && GP_PIN_OUT[2:1] ==
		$past({SIXTH_RATE_CLOCK_OUT_IN, QUARTER_RATE_CLOCK_OUT_IN}))
		else $error("clock defaults not on pins");
endmodule : pin_select_checker

bind shared_pin_function_select pin_select_checker pin_select_checker_inst (.*);

/* strap_board.sv */
// board strap network holding the strap pins through reset
`timescale 1ns/10ps
module strap_board (
	// wanted configuration: bit0 cell, bit1 pci, bit2 wide host
	input  wire logic [2:0] want_in,
	// strap pins
	output logic            cell_out,
	output logic            pci_out,
	output logic            wide_out
);
	// pullup where a function is wanted, pulldown otherwise
	assign cell_out = want_in[0];
	assign pci_out  = want_in[1];
	assign wide_out = want_in[2];
endmodule : strap_board

/* shared_pin_function_select_test.sv */
// self-checking bench for the shared pin function select block
`timescale 1ns/10ps
module shared_pin_function_select_test;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic CLK_IN, RESETN_IN, AWVALID_IN, AWREADY_OUT, WVALID_IN, WREADY_OUT;
	logic BVALID_OUT, BREADY_IN, ARVALID_IN, ARREADY_OUT, RVALID_OUT, RREADY_IN;
	logic [7:0] AWADDR_IN, ARADDR_IN;
	logic [31:0] WDATA_IN, RDATA_OUT;
	logic [3:0] WSTRB_IN;
	logic [1:0] BRESP_OUT, RRESP_OUT;
	logic CELL_BUS_STRAP_PIN_IN, PCI_SEL_STRAP_PIN_IN, HOST_WIDTH_STRAP_IN;
	logic CELL_BUS_SELECT_STRAP_OUT, PCI_SELECT_STRAP_OUT, HOST_PORT_WIDE_OUT;
	logic [15:0] GP_PIN_IN, GP_PIN_OUT, GP_PIN_OE_OUT, en, dir, dat, m;
	logic QUARTER_RATE_CLOCK_OUT_IN, SIXTH_RATE_CLOCK_OUT_IN;
	logic SERIAL2_EXT_CLOCK_IN_OUT;
	logic [6:0] PCI_GP_DRV_IN, PCI_GP_EN_IN, PCI_GP_RCV_OUT, SH1_PIN_IN;
	logic [6:0] SH1_PIN_OUT, SH1_PIN_OE_OUT, SERIAL_ONE_DRV_IN, SERIAL_ONE_EN_IN;
	logic [6:0] SERIAL_ONE_RCV_OUT, CELL_ADDR_DRV_IN, CELL_ADDR_EN_IN;
	logic [6:0] CELL_ADDR_RCV_OUT;
	logic [2:0] SER1_SOLO_DRV_IN, SER1_SOLO_EN_IN, SER1_SOLO_PIN_OUT, want;
	logic [2:0] SER1_SOLO_PIN_OE_OUT, SER2_PIN_IN, SER2_PIN_OUT, SER2_PIN_OE_OUT;
	logic [2:0] SERIAL_TWO_DRV_IN, SERIAL_TWO_EN_IN, SERIAL_TWO_RCV_OUT;
	logic [2:0] EEPROM_DRV_IN, EEPROM_EN_IN, EEPROM_RCV_OUT;
	logic [7:0] CELL_SOLO_DRV_IN, CELL_SOLO_EN_IN, CELL_SOLO_PIN_OUT;
	logic [7:0] CELL_SOLO_PIN_OE_OUT;
	logic [3:0] PCI_SOLO_DRV_IN, PCI_SOLO_EN_IN, PCI_SOLO_PIN_OUT;
	logic [3:0] PCI_SOLO_PIN_OE_OUT;
	logic [41:0] HOST_PIN_IN, HOST_PIN_OUT, HOST_PIN_OE_OUT, HOST_PORT_DRV_IN;
	logic [41:0] HOST_PORT_EN_IN, HOST_PORT_RCV_OUT, PCI_BUS_DRV_IN;
	logic [41:0] PCI_BUS_EN_IN, PCI_BUS_RCV_OUT;
	logic [1:0]  qb[$];
	logic [33:0] qr[$];
	int          err_count, num_checks;

	shared_pin_function_select shared_pin_function_select_inst (.*);
	strap_board strap_board_inst (.want_in(want), .cell_out(CELL_BUS_STRAP_PIN_IN),
		.pci_out(PCI_SEL_STRAP_PIN_IN), .wide_out(HOST_WIDTH_STRAP_IN));

	initial begin
		CLK_IN = 1'b0;
		forever #4 CLK_IN = ~CLK_IN;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	function automatic logic [191:0] rnd();
		for (int i = 0; i < 6; i++) rnd[i*32 +: 32] = $urandom;
	endfunction : rnd

	task automatic drive_pins(input logic on);
		{SH1_PIN_IN, SER2_PIN_IN, HOST_PIN_IN,
			QUARTER_RATE_CLOCK_OUT_IN, SIXTH_RATE_CLOCK_OUT_IN} <= 54'(rnd());
		{HOST_PORT_DRV_IN, HOST_PORT_EN_IN, PCI_BUS_DRV_IN, PCI_BUS_EN_IN}
			<= on ? 168'(rnd()) : 168'h0;
		{SERIAL_ONE_DRV_IN, SERIAL_ONE_EN_IN, CELL_ADDR_DRV_IN, CELL_ADDR_EN_IN,
			SER1_SOLO_DRV_IN, SER1_SOLO_EN_IN, CELL_SOLO_DRV_IN, CELL_SOLO_EN_IN,
			PCI_SOLO_DRV_IN, PCI_SOLO_EN_IN, SERIAL_TWO_DRV_IN, SERIAL_TWO_EN_IN,
			EEPROM_DRV_IN, EEPROM_EN_IN, PCI_GP_DRV_IN, PCI_GP_EN_IN}
			<= on ? 84'(rnd()) : 84'h0;
	endtask : drive_pins

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		qb.push_back(r);
		AWADDR_IN <= a;
		WDATA_IN <= d;
		AWVALID_IN <= 1'b1;
		WVALID_IN <= 1'b1;
		fork
			begin
				do @(posedge CLK_IN); while (AWREADY_OUT !== 1'b1);
				AWVALID_IN <= 1'b0;
			end
			begin
				do @(posedge CLK_IN); while (WREADY_OUT !== 1'b1);
				WVALID_IN <= 1'b0;
			end
		join
		do @(posedge CLK_IN); while (BVALID_OUT !== 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		qr.push_back(e);
		ARADDR_IN <= a;
		ARVALID_IN <= 1'b1;
		do @(posedge CLK_IN); while (ARREADY_OUT !== 1'b1);
		ARVALID_IN <= 1'b0;
		do @(posedge CLK_IN); while (RVALID_OUT !== 1'b1);
	endtask : rd

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// stimulus, monitor and watchdog
	// ----------------------------------------------------------------
	always @(posedge CLK_IN) drive_pins(RESETN_IN);

	always @(posedge CLK_IN) begin
		if (BVALID_OUT === 1'b1 && BREADY_IN === 1'b1 && qb.size() > 0)
			check(BRESP_OUT, qb.pop_front());
		if (RVALID_OUT === 1'b1 && RREADY_IN === 1'b1 && qr.size() > 0)
			check({RRESP_OUT, RDATA_OUT}, qr.pop_front());
	end

	initial begin
		repeat (20000) @(posedge CLK_IN);
		err_count++;
		stop_test();
	end

	initial begin
		void'($urandom(32'h6286));
		{RESETN_IN, AWVALID_IN, WVALID_IN, ARVALID_IN} = 4'h0;
		{BREADY_IN, RREADY_IN, WSTRB_IN, want} = 9'h1F8;
		{AWADDR_IN, ARADDR_IN, WDATA_IN} = 48'h0;
		drive_pins(1'b0);
		for (int s = 0; s < 8; s++) begin
			@(posedge CLK_IN);
			RESETN_IN <= 1'b0;
			want <= s[2:0];
			GP_PIN_IN <= 16'($urandom);
			repeat (5) @(posedge CLK_IN);
			RESETN_IN <= 1'b1;
			repeat (6) @(posedge CLK_IN);
			check({HOST_PORT_WIDE_OUT, PCI_SELECT_STRAP_OUT,
				CELL_BUS_SELECT_STRAP_OUT}, want);
			check(SERIAL2_EXT_CLOCK_IN_OUT, GP_PIN_IN[8]);
			check(PCI_GP_RCV_OUT, want[1] ? GP_PIN_IN[15:9] : 7'h00);
			rd(8'h0C, {18'h0, GP_PIN_IN & 16'hFF06});
			rd(8'h10, {31'h0, want});
			rd(8'h00, 34'h0);
			rd(8'h04, 34'h0);
			en = 16'($urandom);
			dir = 16'($urandom);
			dat = 16'($urandom);
			wr(8'h00, {16'h0, en}, 2'h0);
			wr(8'h04, {16'h0, dir}, 2'h0);
			wr(8'h08, {16'h0, dat}, 2'h0);
			@(posedge CLK_IN);
			m = en & (want[1] ? 16'h0106 : 16'hFF06);
			check(GP_PIN_OE_OUT & m, dir & m);
			check(GP_PIN_OUT & m & dir, dat & m & dir);
			if (!en[8])
				check(GP_PIN_OE_OUT[8], 1'b0);
			rd(8'h00, {18'h0, en & 16'hFF06});
			wr(8'h10, 32'h7, 2'h2);
			rd(8'h14, {2'h2, 32'h0});
			rd(8'h10, {31'h0, want});
			$display("test %0d done", s);
		end
		@(posedge CLK_IN);
		stop_test();
	end
endmodule : shared_pin_function_select_test
